// [spi_command_executor.sv]
// Purpose: serial command executor in front of the transmit and receive queues
// Assumes: spi mode 0, msb first; queue and link signals share ref_clk
// Notes: sclk, cs_n and serial_in are synchronised; sclk must be well below ref_clk/4
`default_nettype none
module spi_command_executor #(
  parameter logic [15:0] DEVICE_ID = 16'h5A3C // arbitrary value
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic fault_n,
  // queue and link side
  input wire logic [15:0] rx_data,
  input wire logic link_busy,
  input wire logic safe_state_req,
  input wire logic drdy_level,
  input wire logic [15:0] interface_status_in,
  input wire logic [15:0] txst_in,
  input wire logic [15:0] rxst_in,
  output spi_exec_pkg::link_out_type link_out,
  output logic safe_state
);

  spi_exec_pkg::state_type st_ff;
  spi_exec_pkg::state_type nxt_st;
  // status word from live flags
  function automatic logic [15:0] status_word(input spi_exec_pkg::state_type s,
                                              input logic drdy);
    logic [15:0] w;
    w = 16'h0000;
    w[10] = drdy;
    w[9] = s.f_srst;
    w[8] = s.f_spi_crc;
    w[6] = s.f_spi_crc;
    w[5:4] = s.dev_state;
    w[1] = s.f_por;
    w[0] = s.f_err;
    return w;
  endfunction
  // register read mux; reserved addresses read zero
  function automatic logic [15:0] reg_read(input spi_exec_pkg::state_type s,
                                           input logic [3:0] a, input logic drdy,
                                           input logic [15:0] i8, input logic [15:0] i9,
                                           input logic [15:0] i10);
    logic [15:0] w;
    w = 16'h0000;
    if (a == spi_exec_pkg::ADDR_ID) begin
      w = DEVICE_ID;
    end else if (a >= spi_exec_pkg::ADDR_CTRL && a <= spi_exec_pkg::ADDR_MASK) begin
      w = s.cfg[a[2:0]];
    end else if (a == spi_exec_pkg::ADDR_STATUS) begin
      w = status_word(s, drdy);
    end else if (a == spi_exec_pkg::ADDR_INTERFACE_STATUS) begin
      w = i8;
    end else if (a == spi_exec_pkg::ADDR_TXST) begin
      w = i9;
    end else if (a == spi_exec_pkg::ADDR_RXST) begin
      w = i10;
    end
    return w;
  endfunction
  // register write with its side effects; mutates a state copy
  function automatic spi_exec_pkg::state_type reg_write(input spi_exec_pkg::state_type s,
                                                        input logic [3:0] a,
                                                        input logic [15:0] d);
    spi_exec_pkg::state_type r;
    r = s;
    if (a >= spi_exec_pkg::ADDR_CTRL && a <= spi_exec_pkg::ADDR_MASK) begin
      r.cfg[a[2:0]] = d;
      if (a == spi_exec_pkg::ADDR_TXLVL || a == spi_exec_pkg::ADDR_RXLVL) begin
        r.cfg[a[2:0]] = d & ~spi_exec_pkg::W1C_BITS;
      end
      if (a == spi_exec_pkg::ADDR_DEV) begin
        r.cfg[a[2:0]] = d & ~spi_exec_pkg::DEV_W1C_BITS;
        if (d[spi_exec_pkg::DEV_EXIT_FS]) begin
          r.dev_state = spi_exec_pkg::DEV_NORMAL;
        end
        if (d[spi_exec_pkg::DEV_FORCE_FS]) begin
          r.dev_state = spi_exec_pkg::DEV_SAFE;
        end
      end
      if (a == spi_exec_pkg::ADDR_TXLVL && d[spi_exec_pkg::LVL_CLR]) begin
        r.link.tx_clear = 1'b1;
      end
      if (a == spi_exec_pkg::ADDR_RXLVL && d[spi_exec_pkg::LVL_CLR]) begin
        r.link.rx_clear = 1'b1;
      end
    end else if (a == spi_exec_pkg::ADDR_STATUS && d[spi_exec_pkg::STAT_CLR]) begin
      r.f_spi_crc = 1'b0;
      r.f_srst = 1'b0;
      r.f_por = 1'b0;
      r.f_err = 1'b0;
    end
    return r;
  endfunction

  // next-state logic
  always_comb begin
    logic rise, fall;
    logic [15:0] w, crc_init, srst_crc, level, nw;
    logic gated, ok, is_read;
    logic [3:0] op;
    rise = 1'b0;
    fall = 1'b0;
    w = 16'h0000;
    crc_init = 16'h0000;
    srst_crc = 16'h0000;
    level = 16'h0000;
    gated = 1'b0;
    ok = 1'b0;
    is_read = 1'b0;
    op = 4'h0;
    nw = 16'h0000;
    nxt_st = st_ff;
    // pin synchronisers
    nxt_st.sclk_s1 = sclk;
    nxt_st.sclk_s2 = st_ff.sclk_s1;
    nxt_st.sclk_s3 = st_ff.sclk_s2;
    nxt_st.cs_s1 = cs_n;
    nxt_st.cs_s2 = st_ff.cs_s1;
    nxt_st.din_s1 = serial_in;
    nxt_st.din_s2 = st_ff.din_s1;
    rise = st_ff.sclk_s2 & ~st_ff.sclk_s3;
    fall = ~st_ff.sclk_s2 & st_ff.sclk_s3;
    // one-cycle requests drop by default
    nxt_st.link.tx_push = 1'b0;
    nxt_st.link.tx_start = 1'b0;
    nxt_st.link.tail_start = 1'b0;
    nxt_st.link.rx_pop = 1'b0;
    nxt_st.link.rx_clear = 1'b0;
    nxt_st.link.tx_clear = 1'b0;
    nxt_st.link.resync = 1'b0;
    crc_init = st_ff.cfg[spi_exec_pkg::ADDR_CTRL][spi_exec_pkg::CTRL_CRC_ALG] ?
               spi_exec_pkg::CRC_INIT_XMODEM : spi_exec_pkg::CRC_INIT_FALSE;
    srst_crc = st_ff.cfg[spi_exec_pkg::ADDR_CTRL][spi_exec_pkg::CTRL_CRC_ALG] ?
               spi_exec_pkg::SRST_CRC_XMODEM : spi_exec_pkg::SRST_CRC_FALSE;
    level = st_ff.cfg[spi_exec_pkg::ADDR_TXLVL];
    op = st_ff.cmd[15:12];
    gated = ~op[0];
    is_read = (op == spi_exec_pkg::OP_DATA_RD_CRC) || (op == spi_exec_pkg::OP_DATA_RD) ||
              (op == spi_exec_pkg::OP_REG_RD_CRC) || (op == spi_exec_pkg::OP_REG_RD);
    w = {st_ff.shift_in, st_ff.din_s2};
    // busy is watched from the link start, so a burst done before the crc is not missed
    if ((st_ff.tail_pending || st_ff.started) && link_busy) begin
      nxt_st.seen_busy = 1'b1;
    end
    if (st_ff.tail_pending && st_ff.seen_busy && !link_busy) begin
      nxt_st.link.tail_start = 1'b1;
      nxt_st.tail_pending = 1'b0;
      nxt_st.seen_busy = 1'b0;
    end
    if (st_ff.cs_s2) begin
      // deselect aborts any frame and releases the output
      nxt_st.phase = spi_exec_pkg::PH_CMD;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.serial_out = 1'b1;
    end else begin
      if (fall && st_ff.phase == spi_exec_pkg::PH_REPLY) begin
        nxt_st.serial_out = st_ff.out_shift[15];
        nxt_st.out_shift = {st_ff.out_shift[14:0], 1'b0};
      end
      if (rise) begin
        nxt_st.shift_in = w[14:0];
        nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
      end
      if (rise && st_ff.bit_cnt == spi_exec_pkg::BIT_LAST) begin
        case (st_ff.phase)
          spi_exec_pkg::PH_CMD: begin
            nxt_st.cmd = w;
            nxt_st.crc_acc = spi_exec_pkg::crc_word(crc_init, w);
            nxt_st.word_cnt = 9'h000;
            nxt_st.link.rx_store_en = 1'b0;
            nxt_st.phase = spi_exec_pkg::PH_CRC;
            nxt_st.addr = w[9:6];
            nxt_st.sh_valid = '0;
            nxt_st.n_words = {5'h00, w[3:0]} + 9'h001;
            if (w[15:12] == spi_exec_pkg::OP_FWD_RD_TAIL) begin
              nxt_st.n_words = {4'h0, w[11:7]} + 9'h001;
              nxt_st.link.tail_count = w[6:0];
              nxt_st.link.rx_store_en = 1'b1;
              nxt_st.started = 1'b0;
              nxt_st.seen_busy = 1'b0;
              nxt_st.phase = spi_exec_pkg::PH_DATA;
            end else if (w[15:12] == spi_exec_pkg::OP_DATA_RD_CRC ||
                         w[15:12] == spi_exec_pkg::OP_DATA_RD) begin
              nxt_st.n_words = {1'b0, w[7:0]} + 9'h001;
            end else if (w[15:12] == spi_exec_pkg::OP_REG_WR_CRC ||
                         w[15:12] == spi_exec_pkg::OP_REG_WR) begin
              nxt_st.phase = spi_exec_pkg::PH_DATA;
            end
          end
          spi_exec_pkg::PH_DATA: begin
            nxt_st.crc_acc = spi_exec_pkg::crc_word(st_ff.crc_acc, w);
            nxt_st.word_cnt = st_ff.word_cnt + 9'h001;
            nxt_st.addr = st_ff.addr + 4'h1;
            if (op == spi_exec_pkg::OP_FWD_RD_TAIL) begin
              nxt_st.link.tx_push = 1'b1;
              nxt_st.link.tx_word = w;
              if (!st_ff.started && ({7'h00, st_ff.word_cnt} >= level[8:0] ||
                  st_ff.word_cnt + 9'h001 == st_ff.n_words)) begin
                nxt_st.link.tx_start = 1'b1;
                nxt_st.started = 1'b1;
              end
            end else if (gated) begin
              if (st_ff.addr >= spi_exec_pkg::ADDR_CTRL &&
                  st_ff.addr <= spi_exec_pkg::ADDR_STATUS) begin
                nxt_st.shadow[st_ff.addr[2:0]] = w;
                nxt_st.sh_valid[st_ff.addr[2:0]] = 1'b1;
              end
            end else begin
              nxt_st = reg_write(nxt_st, st_ff.addr, w);
            end
            if (st_ff.word_cnt + 9'h001 == st_ff.n_words) begin
              nxt_st.phase = spi_exec_pkg::PH_CRC;
            end
          end
          spi_exec_pkg::PH_CRC: begin
            ok = (w == st_ff.crc_acc);
            nxt_st.word_cnt = 9'h000;
            nxt_st.phase = spi_exec_pkg::PH_REPLY;
            nw = status_word(st_ff, drdy_level);
            if (op == spi_exec_pkg::OP_SOFT_RST) begin
              if (w == srst_crc && !link_busy) begin
                nxt_st.cfg = spi_exec_pkg::CFG_RESET;
                nxt_st.sh_valid = '0;
                nxt_st.f_spi_crc = 1'b0;
                nxt_st.f_srst = 1'b0;
                nxt_st.f_por = 1'b1;
                nxt_st.f_err = 1'b1;
                nxt_st.dev_state = spi_exec_pkg::DEV_NORMAL;
                nxt_st.link.resync = 1'b1;
                nxt_st.link.rx_clear = 1'b1;
                nxt_st.tail_pending = 1'b0;
                nxt_st.link.rx_store_en = 1'b0;
              end else begin
                nxt_st.f_srst = 1'b1;
              end
              nw = status_word(nxt_st, drdy_level);
            end else if (!ok && !gated) begin
              nxt_st.f_spi_crc = 1'b1;
              if (!st_ff.cfg[spi_exec_pkg::ADDR_MASK][spi_exec_pkg::MASK_SPI_CRC]) begin
                nxt_st.f_err = 1'b1;
              end
              nw = status_word(nxt_st, drdy_level);
            end
            if (op == spi_exec_pkg::OP_FWD_RD_TAIL) begin
              nxt_st.tail_pending = st_ff.link.tail_count != 7'h00;
            end
            if (op == spi_exec_pkg::OP_REG_WR_CRC && ok) begin
              for (int i = 1; i <= 6; i++) begin
                if (st_ff.sh_valid[i]) begin
                  nxt_st = reg_write(nxt_st, 4'(i), st_ff.shadow[i]);
                end
              end
              nw = status_word(nxt_st, drdy_level);
            end
            if (is_read) begin
              nxt_st.n_words = st_ff.n_words;
              if (gated && !ok) begin
                nxt_st.phase = spi_exec_pkg::PH_DONE;
              end else if (op[3:1] == spi_exec_pkg::OP_DATA_RD_CRC[3:1]) begin
                nw = rx_data;
                nxt_st.link.rx_pop = 1'b1;
              end else begin
                nw = reg_read(st_ff, st_ff.addr, drdy_level, interface_status_in, txst_in,
                              rxst_in);
                nxt_st.addr = st_ff.addr + 4'h1;
              end
            end else begin
              nxt_st.n_words = 9'h001;
              if (st_ff.cfg[spi_exec_pkg::ADDR_CTRL][spi_exec_pkg::CTRL_ACK_DIS]) begin
                nxt_st.phase = spi_exec_pkg::PH_DONE;
              end
            end
            nxt_st.out_shift = nw;
            nxt_st.reply_crc = spi_exec_pkg::crc_word(crc_init, nw);
          end
          spi_exec_pkg::PH_REPLY: begin
            nxt_st.word_cnt = st_ff.word_cnt + 9'h001;
            if (st_ff.word_cnt + 9'h001 < st_ff.n_words) begin
              if (op[3:1] == spi_exec_pkg::OP_DATA_RD_CRC[3:1]) begin
                nw = rx_data;
                nxt_st.link.rx_pop = 1'b1;
              end else begin
                nw = reg_read(st_ff, st_ff.addr, drdy_level, interface_status_in, txst_in, rxst_in);
                nxt_st.addr = st_ff.addr + 4'h1;
              end
              nxt_st.out_shift = nw;
              nxt_st.reply_crc = spi_exec_pkg::crc_word(st_ff.reply_crc, nw);
            end else if (st_ff.word_cnt + 9'h001 == st_ff.n_words) begin
              nxt_st.out_shift = st_ff.reply_crc;
            end else begin
              nxt_st.phase = spi_exec_pkg::PH_DONE;
            end
          end
          default: begin
            nxt_st.phase = spi_exec_pkg::PH_DONE; // output keeps its last bit until deselect
          end
        endcase
      end
    end
    // a fail-safe request wins over a same-cycle exit write
    if (safe_state_req) begin
      nxt_st.dev_state = spi_exec_pkg::DEV_SAFE;
    end
    // output enable follows the state of this cycle, fault_n the next-state error flag
    nxt_st.serial_out_oe = ~st_ff.cs_s2 &
                           ~st_ff.cfg[spi_exec_pkg::ADDR_CTRL][spi_exec_pkg::CTRL_SDO_DIS];
    nxt_st.fault_n = ~nxt_st.f_err;
    if (!reset_n) begin
      nxt_st = '0;
      nxt_st.cs_s1 = 1'b1;
      nxt_st.cs_s2 = 1'b1;
      nxt_st.phase = spi_exec_pkg::PH_CMD;
      nxt_st.cfg = spi_exec_pkg::CFG_RESET;
      nxt_st.f_por = 1'b1;
      nxt_st.f_err = 1'b1;
      nxt_st.serial_out = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  assign serial_out = st_ff.serial_out;
  assign serial_out_oe = st_ff.serial_out_oe;
  assign fault_n = st_ff.fault_n;
  assign link_out = st_ff.link;
  assign safe_state = (st_ff.dev_state == spi_exec_pkg::DEV_SAFE);

endmodule
`default_nettype wire

// [spi_exec_checker.sv]
// Purpose: port assertions for the serial command executor
// Assumes: one ref_clk domain, synchronous active-low reset
// Notes: bound to every executor instance
`default_nettype none
module spi_exec_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // pins
  input wire logic cs_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic fault_n,
  // link side
  input wire logic link_busy,
  input wire logic safe_state_req,
  input wire spi_exec_pkg::link_out_type link_out,
  input wire logic safe_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // reset itself cannot disable the check of the reset levels
  reset_quiet_a: assert property (disable iff (1'b0)
    !reset_n |=> !fault_n && serial_out && !serial_out_oe && !safe_state && link_out == '0)
    else $error("outputs not quiet in reset");
  idle_high_a: assert property (cs_n [*6] |-> serial_out && !serial_out_oe)
    else $error("serial line active while deselected");
  tail_cause_a: assert property (
    link_out.tail_start |-> !link_busy && link_out.tail_count != 7'h00)
    else $error("tail start without idle link");
  start_once_a: assert property (link_out.tx_start |=> !link_out.tx_start [*8])
    else $error("link start repeated");
  push_framed_a: assert property (link_out.tx_push |-> !cs_n)
    else $error("push outside a frame");
  resync_idle_a: assert property (link_out.resync |-> !link_busy && !$past(link_busy))
    else $error("resync while link busy");
  resync_fault_a: assert property (link_out.resync |-> ##[0:3] !fault_n)
    else $error("error flag not set by soft reset");
  safe_entry_a: assert property (safe_state_req |-> ##[1:3] safe_state)
    else $error("safe state not entered");
  // main scenarios reached
  tail_c: cover property (link_out.tail_start);
  late_push_c: cover property (link_out.tx_start ##[1:400] link_out.tx_push);
  safe_exit_c: cover property (safe_state ##1 !safe_state);
endmodule
bind spi_command_executor spi_exec_checker chk (.ref_clk, .reset_n, .cs_n, .serial_out,
  .serial_out_oe, .fault_n, .link_busy, .safe_state_req, .link_out, .safe_state);
`default_nettype wire

// [spi_exec_pkg.sv]
// Purpose: shared constants and types for the serial command executor
// Assumes: 16-bit words, crc-16 polynomial 0x1021 for both algorithms
// Notes: register map indices double as the command address field
`default_nettype none
package spi_exec_pkg;
  // word geometry
  localparam int WORD_W = 16;
  localparam logic [3:0] BIT_LAST = 4'hF;
  // register addresses
  localparam logic [3:0] ADDR_ID = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_LINK = 4'h2;
  localparam logic [3:0] ADDR_TXLVL = 4'h3;
  localparam logic [3:0] ADDR_RXLVL = 4'h4;
  localparam logic [3:0] ADDR_DEV = 4'h5;
  localparam logic [3:0] ADDR_MASK = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_INTERFACE_STATUS = 4'h8;
  localparam logic [3:0] ADDR_TXST = 4'h9;
  localparam logic [3:0] ADDR_RXST = 4'hA;
  // reset values of the stored registers, index 6 down to 1
  localparam logic [6:1][15:0] CFG_RESET = {16'h0000, 16'h0000, 16'h00FF, 16'h01FF,
                                            16'h0000, 16'h00A0};
  // command opcodes, bits 15:12 of the command word
  localparam logic [3:0] OP_FWD_RD_TAIL = 4'h7;
  localparam logic [3:0] OP_DATA_RD_CRC = 4'h8;
  localparam logic [3:0] OP_DATA_RD = 4'h9;
  localparam logic [3:0] OP_REG_WR_CRC = 4'hA;
  localparam logic [3:0] OP_REG_WR = 4'hB;
  localparam logic [3:0] OP_REG_RD_CRC = 4'hC;
  localparam logic [3:0] OP_REG_RD = 4'hD;
  localparam logic [3:0] OP_SOFT_RST = 4'hE;
  // field bits
  localparam int CTRL_ACK_DIS = 0;
  localparam int CTRL_SDO_DIS = 1;
  localparam int CTRL_CRC_ALG = 2;
  localparam int LVL_CLR = 15;
  localparam int DEV_FORCE_FS = 2;
  localparam int DEV_EXIT_FS = 0;
  localparam int MASK_SPI_CRC = 0;
  localparam int STAT_CLR = 15;
  localparam logic [15:0] W1C_BITS = 16'h8000;
  localparam logic [15:0] DEV_W1C_BITS = 16'h0005;
  // crc constants
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT_FALSE = 16'hFFFF;
  localparam logic [15:0] CRC_INIT_XMODEM = 16'h0000;
  localparam logic [15:0] SRST_CRC_FALSE = 16'hD383;
  localparam logic [15:0] SRST_CRC_XMODEM = 16'hCE8C;
  // device states
  localparam logic [1:0] DEV_NORMAL = 2'h0;
  localparam logic [1:0] DEV_SAFE = 2'h3;

  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_DATA = 3'b001,
    PH_CRC = 3'b010,
    PH_REPLY = 3'b011,
    PH_DONE = 3'b100
  } phase_type;

  // requests toward the queues and the link
  typedef struct packed {
    logic tx_push;
    logic [15:0] tx_word;
    logic tx_start;
    logic tail_start;
    logic [6:0] tail_count;
    logic rx_store_en;
    logic rx_pop;
    logic rx_clear;
    logic tx_clear;
    logic resync;
  } link_out_type;

  typedef struct packed {
    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2;
    logic din_s1, din_s2;
    phase_type phase;
    logic [15:0] cmd;
    logic [14:0] shift_in;
    logic [3:0] bit_cnt;
    logic [8:0] word_cnt;
    logic [8:0] n_words;
    logic [3:0] addr;
    logic [15:0] crc_acc;
    logic [15:0] reply_crc;
    logic [15:0] out_shift;
    logic [6:1][15:0] cfg;
    logic [6:1][15:0] shadow;
    logic [6:1] sh_valid;
    logic f_spi_crc, f_srst, f_por, f_err;
    logic [1:0] dev_state;
    logic started;
    logic seen_busy;
    logic tail_pending;
    link_out_type link;
    logic serial_out;
    logic serial_out_oe;
    logic fault_n;
  } state_type;

  // one 16-bit word through crc-16, msb first
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// [spi_host_model.sv]
// Purpose: spi host clocking whole frames in mode 0
// Assumes: sclk high for eight and low for nine ref_clk cycles, well below the sync limit
// Notes: the bench fills txw and reads rxw
`default_nettype none
module spi_host_model (
  // clock
  input wire logic ref_clk,
  // serial pins
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] txw [16];
  logic [15:0] rxw [16];
  logic last = 1'b1;
  // idle pins at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b1;
  end
  // a released line reads inverted so a stale level never passes
  task automatic run(input int n);
    for (int w = 0; w < n; w++) begin
      for (int b = 15; b >= 0; b--) begin
        @(posedge ref_clk) #1;
        cs_n = 1'b0;
        serial_in = txw[w][b];
        repeat (8) @(posedge ref_clk);
        #1 sclk = 1'b1;
        last = serial_out_oe ? serial_out : ~last;
        rxw[w][b] = last;
        repeat (8) @(posedge ref_clk);
        #1 sclk = 1'b0;
      end
    end
    repeat (8) @(posedge ref_clk);
    #1 cs_n = 1'b1;
    serial_in = 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [test_spi_command_executor.sv]
// Purpose: self-checking bench for the serial command executor
// Assumes: receive queue head is a counter, link busy follows each start
// Notes: expected crcs come from a local crc-16 model
`default_nettype none
module test_spi_command_executor;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, reset_n, sclk, cs_n, serial_in, serial_out, serial_out_oe, fault_n, safe_state;
  logic busy_force, safe_state_req, drdy_level, link_busy;
  logic [15:0] rx_data, cinit;
  logic [7:0] rx_head, h;
  logic [6:0] tail_n;
  logic [15:0] pushed [4];
  spi_exec_pkg::link_out_type link_out;
  int errors = 0, total_checks = 0, cycles = 0, busy_cnt = 0;
  int pushes = 0, at_start = 0, starts = 0, tails = 0, stores = 0, clears = 0, syncs = 0;
  // address beside the word it reads back
  logic [19:0] rows [12] = '{20'h01234, 20'h100A0, 20'h20000, 20'h301FF, 20'h400FF,
    20'h50000, 20'h60000, 20'h81357, 20'h92468, 20'hA3579, 20'hB0000, 20'hF0000};
  assign rx_data = {8'hA5, rx_head};
  assign link_busy = busy_force | (busy_cnt != 0);
  spi_command_executor #(.DEVICE_ID(16'h1234)) DUT ( // arbitrary identity value
    .ref_clk, .reset_n, .sclk, .cs_n, .serial_in, .serial_out, .serial_out_oe, .fault_n,
    .rx_data, .link_busy, .safe_state_req, .drdy_level, .interface_status_in(16'h1357),
    .txst_in(16'h2468), .rxst_in(16'h3579), .link_out, .safe_state);
  spi_host_model host (.ref_clk, .sclk, .cs_n, .serial_in, .serial_out, .serial_out_oe);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // far-side model: queue pops, busy window after start, event counts, timeout
  always @(posedge ref_clk) begin
    if (link_out.rx_pop) rx_head <= rx_head + 8'h01;
    if (link_out.tx_push) pushed[pushes[1:0]] <= link_out.tx_word;
    pushes <= pushes + int'(link_out.tx_push);
    busy_cnt <= link_out.tx_start ? 400 : (busy_cnt == 0 ? 0 : busy_cnt - 1);
    if (link_out.tx_start) at_start <= pushes;
    starts <= starts + int'(link_out.tx_start);
    if (link_out.tail_start) tail_n <= link_out.tail_count;
    tails <= tails + int'(link_out.tail_start);
    stores <= stores + int'(link_out.rx_store_en);
    clears <= clears + int'(link_out.rx_clear);
    syncs <= syncs + int'(link_out.resync);
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errors++;
      finish_test();
    end
  end
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // command, data already in txw, crc inverted when bad, then idle reply words
  task automatic frame(input logic [15:0] cmd, input int nd, input int nr, input logic bad);
    logic [15:0] c;
    c = crc16(cinit, cmd);
    host.txw[0] = cmd;
    for (int i = 1; i <= nd; i++) c = crc16(c, host.txw[i]);
    host.txw[nd + 1] = bad ? ~c : c;
    for (int i = nd + 2; i < nd + 2 + nr; i++) host.txw[i] = 16'hFFFF;
    host.run(nd + 2 + nr);
  endtask
  task automatic rd(input logic [3:0] a, input int n, input logic g, input logic bad);
    frame({g ? 4'hC : 4'hD, 2'h0, a, 2'h0, 4'(n - 1)}, 0, n + 1, bad);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic g, input logic bad);
    host.txw[1] = d;
    frame({g ? 4'hA : 4'hB, 2'h0, a, 6'h00}, 1, 2, bad);
    if (a != 4'h1) check(host.rxw[4], crc16(cinit, host.rxw[3]));
  endtask
  task automatic srst(input logic [15:0] c);
    host.txw[0] = 16'hE1E1;
    host.txw[1] = c;
    host.txw[2] = 16'hFFFF;
    host.txw[3] = 16'hFFFF;
    host.run(4);
  endtask
  task automatic finish_test();
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    reset_n = 1'b0;
    busy_force = 1'b0;
    safe_state_req = 1'b0;
    drdy_level = 1'b1;
    cinit = 16'hFFFF;
    rx_head = 8'h00;
    repeat (3) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    check({12'h000, serial_out, serial_out_oe, fault_n, safe_state}, 16'h0008);
    for (int i = 0; i < 12; i++) begin
      rd(rows[i][19:16], 1, 1'b0, 1'b0);
      check(host.rxw[2], rows[i][15:0]);
      check(host.rxw[3], crc16(cinit, rows[i][15:0]));
    end
    // identity write ignored, gated bad write dropped, ungated bad write lands
    wr(4'h0, 16'hFFFF, 1'b0, 1'b0);
    wr(4'h7, 16'h8000, 1'b0, 1'b0);
    wr(4'h6, 16'h0001, 1'b1, 1'b1);
    wr(4'h2, 16'h0003, 1'b0, 1'b1);
    rd(4'h0, 8, 1'b0, 1'b0);
    check(host.rxw[2], 16'h1234);
    check(host.rxw[4], 16'h0003);
    check(host.rxw[8], 16'h0000);
    check(host.rxw[9] & 16'h0041, 16'h0041);
    check(16'(fault_n), 16'h0000);
    // committed mask keeps the fault pin high on a later mismatch
    wr(4'h7, 16'h8000, 1'b0, 1'b0);
    wr(4'h6, 16'h0001, 1'b1, 1'b0);
    rd(4'h0, 1, 1'b0, 1'b1);
    check(host.rxw[2], 16'h1234);
    check(16'(fault_n), 16'h0001);
    rd(4'h1, 2, 1'b1, 1'b1);
    check(host.rxw[2] & host.rxw[3] & host.rxw[4], 16'hFFFF);
    frame(16'h8001, 0, 3, 1'b1);
    check(host.rxw[2] & host.rxw[3] & host.rxw[4], 16'hFFFF);
    h = rx_head;
    frame(16'h9001, 0, 3, 1'b1);
    check(host.rxw[2], {8'hA5, h});
    check(host.rxw[3], {8'hA5, h + 8'h01});
    check(host.rxw[4], crc16(crc16(cinit, {8'hA5, h}), {8'hA5, h + 8'h01}));
    // forward read at start level 1, bad crc must not stop the link
    wr(4'h3, 16'h0001, 1'b0, 1'b0);
    for (int i = 1; i <= 3; i++) host.txw[i] = 16'h1111 * 16'(i);
    frame({4'h7, 5'h02, 7'h02}, 3, 2, 1'b1);
    for (int i = 0; i < 1000 && tails == 0; i++) @(posedge ref_clk);
    #1 check(16'(pushes), 16'h0003);
    for (int i = 0; i < 3; i++) check(pushed[i], 16'h1111 * 16'(i + 1));
    check(16'(starts), 16'h0001);
    check(16'(at_start == 1 || at_start == 2), 16'h0001);
    check({8'h00, 8'(tails), 1'b0, tail_n}, 16'h0102);
    check(16'(stores != 0), 16'h0001);
    check(host.rxw[6], crc16(cinit, host.rxw[5]));
    // soft reset refused while the link sends
    busy_force = 1'b1;
    srst(16'hD383);
    #1 busy_force = 1'b0;
    rd(4'h7, 1, 1'b0, 1'b0);
    check(host.rxw[2] & 16'h0200, 16'h0200);
    #1 safe_state_req = 1'b1;
    @(posedge ref_clk) #1 safe_state_req = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 check(16'(safe_state), 16'h0001);
    wr(4'h1, 16'h0004, 1'b0, 1'b0);
    cinit = 16'h0000;
    srst(16'hCE8C);
    cinit = 16'hFFFF;
    check({14'h0000, safe_state, fault_n}, 16'h0000);
    check(16'(clears != 0 && syncs != 0), 16'h0001);
    // one end byte per driver of a three-deep chain after the soft reset
    host.txw[1] = 16'h0000;
    frame({4'h7, 5'h00, 7'h03}, 1, 2, 1'b0);
    check({8'(tails), 1'b0, tail_n}, 16'h0203);
    rd(4'h1, 7, 1'b0, 1'b0);
    check(host.rxw[2], 16'h00A0);
    check(host.rxw[8] & 16'h0273, 16'h0003);
    finish_test();
  end
endmodule
`default_nettype wire
